// ### hw/tpo_pkg.sv
// Constants and types shared by the time-proportioning output block
package tpo_pkg;

    // ------------------------------------------------------------------
    // Clock and timebase
    // ------------------------------------------------------------------
    localparam int unsigned CLK_HZ         = 20_000_000;
    localparam int unsigned TICK_TIME_US   = 10_000;
    localparam int unsigned TICK_CYCLES    = (CLK_HZ / 1_000_000) * TICK_TIME_US;
    localparam int unsigned TICKS_PER_SEC  = 1_000_000 / TICK_TIME_US;

    // ------------------------------------------------------------------
    // Automatic minimum pulse per hardware, in milliseconds and in ticks
    // ------------------------------------------------------------------
    localparam int unsigned RELAY_TPO_MIN_MS = 1000;
    localparam int unsigned LOGIC_TPO_MIN_MS = 50;
    localparam int unsigned VALVE_MIN_MS     = 100;
    localparam int unsigned TICK_MS          = TICK_TIME_US / 1000;
    localparam logic [15:0] RELAY_TPO_MIN    = 16'(RELAY_TPO_MIN_MS / TICK_MS);
    localparam logic [15:0] LOGIC_TPO_MIN    = 16'(LOGIC_TPO_MIN_MS / TICK_MS);
    localparam logic [15:0] VALVE_MIN        = 16'(VALVE_MIN_MS / TICK_MS);

    // ------------------------------------------------------------------
    // Settings, demand scale, arithmetic widths
    // ------------------------------------------------------------------
    localparam logic [15:0] MIN_PULSE_RESET  = 16'h0000;
    localparam logic [9:0]  CYCLE_RESET      = 10'h000;
    localparam logic [9:0]  CYCLE_MAX_SEC    = 10'h258;
    localparam logic [9:0]  DEMAND_FULL      = 10'h3e8;
    localparam logic [9:0]  RIPPLE_HALF_GAIN = 10'h1f4;
    localparam int unsigned COUNT_W          = 26;
    localparam int unsigned PROD_W           = 40;

    typedef enum logic [1:0] {
        MODE_ON_OFF      = 2'b00,
        MODE_TIME_PROP   = 2'b01,
        MODE_VALVE_RAISE = 2'b10,
        MODE_VALVE_LOWER = 2'b11
    } output_mode_type;

endpackage

// ### hw/tick_timebase.sv
// Divider that makes the fixed sub-second timebase tick
`timescale 1ns/1ps

module tick_timebase #(
    parameter int unsigned CYCLES = tpo_pkg::TICK_CYCLES
) (
    input  wire logic clk,
    input  wire logic rst_n,
    output logic      tick
);

    localparam int unsigned CNT_W = (CYCLES > 1) ? $clog2(CYCLES) : 1;
    localparam logic [CNT_W-1:0] LAST = CNT_W'(CYCLES - 1);

    logic [CNT_W-1:0] count;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count <= '0;
        end else if (count == LAST) begin
            count <= '0;
        end else begin
            count <= count + CNT_W'(1);
        end
    end

    // One-cycle pulse per period of the timebase
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tick <= 1'b0;
        end else begin
            tick <= (count == LAST);
        end
    end

endmodule

// ### hw/time_proportioning_output.sv
// Time-proportioning output channel: demand to timed on/off switching
`timescale 1ns/1ps

module time_proportioning_output #(
    parameter int unsigned TICK_CYCLES = tpo_pkg::TICK_CYCLES
) (
    input  wire logic                     clk,
    input  wire logic                     rst_n,
    input  wire logic [9:0]               demand,
    input  tpo_pkg::output_mode_type      output_mode,
    input  wire logic                     hw_is_relay,
    input  wire logic                     invert_sense,
    input  wire logic                     switch_request,
    input  wire logic                     digital_in,
    input  wire logic                     cfg_load,
    input  wire logic                     cfg_defaults,
    input  wire logic [15:0]              cfg_min_pulse,
    input  wire logic [9:0]               cfg_cycle_period,
    output logic [15:0]                   min_pulse_setting,
    output logic [9:0]                    cycle_period_setting,
    output logic                          drive_out,
    output logic                          output_on,
    output logic                          input_active,
    output logic                          ripple_mode
);

    localparam int unsigned CW = tpo_pkg::COUNT_W;
    typedef logic        [tpo_pkg::PROD_W-1:0] prod_type;
    typedef logic signed [tpo_pkg::PROD_W-1:0] acc_type;
    typedef logic        [CW-1:0]              count_type;

    // ------------------------------------------------------------------
    // Timebase
    // ------------------------------------------------------------------
    logic tick;

    tick_timebase #(
        .CYCLES (TICK_CYCLES)
    ) u_tick (
        .clk   (clk),
        .rst_n (rst_n),
        .tick  (tick)
    );

    // ------------------------------------------------------------------
    // Configuration settings
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            min_pulse_setting    <= tpo_pkg::MIN_PULSE_RESET;
            cycle_period_setting <= tpo_pkg::CYCLE_RESET;
        end else if (cfg_defaults) begin
            min_pulse_setting    <= tpo_pkg::MIN_PULSE_RESET;
            cycle_period_setting <= tpo_pkg::CYCLE_RESET;
        end else if (cfg_load) begin
            min_pulse_setting <= cfg_min_pulse;
            // Out-of-range periods saturate rather than wrap
            if (cfg_cycle_period > tpo_pkg::CYCLE_MAX_SEC) begin
                cycle_period_setting <= tpo_pkg::CYCLE_MAX_SEC;
            end else begin
                cycle_period_setting <= cfg_cycle_period;
            end
        end
    end

    // ------------------------------------------------------------------
    // Effective minimum pulse, demand and period
    // ------------------------------------------------------------------
    logic [15:0] hw_min;
    logic [15:0] min_ticks;
    logic [9:0]  duty;
    logic [15:0] period_ticks;
    logic        timed_mode;
    logic        is_valve;

    assign is_valve   = (output_mode == tpo_pkg::MODE_VALVE_RAISE) ||
                        (output_mode == tpo_pkg::MODE_VALVE_LOWER);
    assign timed_mode = (output_mode != tpo_pkg::MODE_ON_OFF);

    always_comb begin
        if (is_valve) begin
            hw_min = tpo_pkg::VALVE_MIN;
        end else if (hw_is_relay) begin
            hw_min = tpo_pkg::RELAY_TPO_MIN;
        end else begin
            hw_min = tpo_pkg::LOGIC_TPO_MIN;
        end
    end

    // Zero is below every hardware minimum, so auto and clipping share a path
    assign min_ticks = (min_pulse_setting < hw_min) ? hw_min : min_pulse_setting;

    assign duty = (demand > tpo_pkg::DEMAND_FULL) ? tpo_pkg::DEMAND_FULL : demand;
    assign period_ticks = 16'(cycle_period_setting * tpo_pkg::TICKS_PER_SEC);
    assign ripple_mode  = timed_mode && (cycle_period_setting == tpo_pkg::CYCLE_RESET);

    // ------------------------------------------------------------------
    // Switching decisions
    // ------------------------------------------------------------------
    logic      active;
    count_type phase_cnt;
    count_type cyc_cnt;
    count_type on_cnt;
    acc_type   err;

    prod_type on_scaled;
    prod_type duty_period;
    prod_type duty_elapsed;
    prod_type off_share;
    prod_type duty_min;
    acc_type  ripple_band;
    logic     min_ok;
    logic     cyc_on_end;
    logic     cyc_restart;
    logic     next_active;

    assign min_ok       = phase_cnt >= count_type'(min_ticks);
    assign on_scaled    = prod_type'(tpo_pkg::DEMAND_FULL) * prod_type'(on_cnt);
    assign duty_period  = prod_type'(duty) * prod_type'(period_ticks);
    assign duty_elapsed = prod_type'(duty) * prod_type'(cyc_cnt);
    assign off_share    = prod_type'(tpo_pkg::DEMAND_FULL - duty) * prod_type'(on_cnt);
    assign duty_min     = prod_type'(duty) * prod_type'(min_ticks);
    // Half band of 500 pulses gives a 4-pulse period at half demand
    assign ripple_band  = acc_type'(prod_type'(tpo_pkg::RIPPLE_HALF_GAIN) *
                                    prod_type'(min_ticks));

    // On phase ends once the share of the set period is delivered and
    // enough on-time exists for a minimum off phase to keep the duty
    assign cyc_on_end  = min_ok && (on_scaled >= duty_period) &&
                         (off_share >= duty_min);
    // Cycle closes at the set period, later only while the minimum off phase runs or delivered on-time still exceeds the duty
    assign cyc_restart = min_ok && (cyc_cnt >= count_type'(period_ticks)) &&
                         (on_scaled <= duty_elapsed);

    always_comb begin
        next_active = active;
        if (!timed_mode) begin
            next_active = switch_request;
        end else if (tick) begin
            if (ripple_mode) begin
                // Hysteresis on integrated error keeps ripple amplitude fixed
                if (!active && min_ok && (err >= ripple_band)) begin
                    next_active = 1'b1;
                end else if (active && min_ok && (err <= -ripple_band)) begin
                    next_active = 1'b0;
                end
            end else if (active) begin
                next_active = !cyc_on_end;
            end else if (cyc_restart) begin
                next_active = (duty != 10'h000);
            end
        end
    end

    // ------------------------------------------------------------------
    // Phase timing
    // ------------------------------------------------------------------
    function automatic count_type sat_inc(input count_type value);
        if (value == '1) begin
            sat_inc = value;
        end else begin
            sat_inc = value + count_type'(1);
        end
    endfunction

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            active <= 1'b0;
        end else begin
            active <= next_active;
        end
    end

    // Time since the last transition, counted only on ticks
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_cnt <= '0;
        end else if (next_active != active) begin
            // Switching tick is the first tick of the new phase, so a phase
            // lasts exactly the minimum and no stretched period gains a tick
            phase_cnt <= count_type'(1);
        end else if (tick) begin
            phase_cnt <= sat_inc(phase_cnt);
        end
    end

    // Elapsed and on-time counts of the running constant-cycle period
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cyc_cnt <= '0;
            on_cnt  <= '0;
        end else if (!timed_mode || ripple_mode) begin
            cyc_cnt <= '0;
            on_cnt  <= '0;
        end else if (tick) begin
            if (!active && cyc_restart) begin
                cyc_cnt <= count_type'(1);
                on_cnt  <= count_type'(next_active);
            end else begin
                cyc_cnt <= sat_inc(cyc_cnt);
                if (next_active) begin
                    on_cnt <= sat_inc(on_cnt);
                end
            end
        end
    end

    // Error integrator of demand minus delivered power
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            err <= '0;
        end else if (!ripple_mode) begin
            err <= '0;
        end else if (tick) begin
            if (next_active) begin
                err <= err + acc_type'(duty) - acc_type'(tpo_pkg::DEMAND_FULL);
            end else begin
                err <= err + acc_type'(duty);
            end
        end
    end

    // ------------------------------------------------------------------
    // Pin polarity
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            drive_out    <= 1'b0;
            output_on    <= 1'b0;
            input_active <= 1'b0;
        end else begin
            drive_out    <= next_active ^ invert_sense;
            output_on    <= next_active;
            input_active <= digital_in ^ invert_sense;
        end
    end

endmodule

// ### dv/actuator_load.sv
// Behavioural relay or contactor load that times each on and off phase of the output
`timescale 1ns/1ps

module actuator_load (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        drive_out,
    output logic [31:0]      on_len,
    output logic [31:0]      off_len,
    output logic [31:0]      n_edges
);
    logic        last;
    logic [31:0] run;

    // Lengths in clocks; a phase is only recorded once the next switch ends it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            {last, run, on_len, off_len, n_edges} <= 129'h0;
        end else if (drive_out != last) begin
            last    <= drive_out;
            run     <= 32'h1;
            n_edges <= n_edges + 32'h1;
            if (last) begin
                on_len <= run;
            end else begin
                off_len <= run;
            end
        end else begin
            run <= run + 32'h1;
        end
    end
endmodule

// ### dv/tpo_properties.sv
// Port-level assertions for the time-proportioning output channel
`timescale 1ns/1ps

module tpo_properties #(
    parameter int unsigned TICK_CYCLES = tpo_pkg::TICK_CYCLES
) (
    input wire logic                clk,
    input wire logic                rst_n,
    input wire logic [9:0]          demand,
    input tpo_pkg::output_mode_type output_mode,
    input wire logic                hw_is_relay,
    input wire logic                invert_sense,
    input wire logic                switch_request,
    input wire logic                digital_in,
    input wire logic                cfg_load,
    input wire logic                cfg_defaults,
    input wire logic [15:0]         cfg_min_pulse,
    input wire logic [9:0]          cfg_cycle_period,
    input wire logic [15:0]         min_pulse_setting,
    input wire logic [9:0]          cycle_period_setting,
    input wire logic                drive_out,
    input wire logic                output_on,
    input wire logic                input_active,
    input wire logic                ripple_mode
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    logic        timed, prev_on;
    logic [15:0] hw_min, need;
    logic [31:0] gap, floor_gap;

    assign timed     = output_mode != tpo_pkg::MODE_ON_OFF;
    assign hw_min    = output_mode[1] ? tpo_pkg::VALVE_MIN
                     : (hw_is_relay ? tpo_pkg::RELAY_TPO_MIN : tpo_pkg::LOGIC_TPO_MIN);
    assign need      = (min_pulse_setting > hw_min) ? min_pulse_setting : hw_min;
    // One tick of slack: a phase may start anywhere inside a tick
    assign floor_gap = 32'(need) * TICK_CYCLES - TICK_CYCLES;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_on <= 1'b0;
            gap     <= 32'h0;
        end else begin
            prev_on <= output_on;
            gap     <= (output_on != prev_on) ? 32'h1 : gap + 32'h1;
        end
    end

    sequence s_load;
        cfg_load && !cfg_defaults;
    endsequence

    chk_min_spacing: assert property (
        timed && output_on != prev_on |-> gap > floor_gap)
        else $error("output switched inside the minimum pulse");
    chk_cfg_clear: assert property (cfg_defaults |=>
        min_pulse_setting == 16'h0000 && cycle_period_setting == 10'h000)
        else $error("settings not cleared");
    chk_cfg_load: assert property (s_load ##0 cfg_cycle_period <= 10'h258 |=>
        cycle_period_setting == $past(cfg_cycle_period) &&
        min_pulse_setting == $past(cfg_min_pulse))
        else $error("settings not loaded");
    chk_cycle_clip: assert property (s_load ##0 cfg_cycle_period > 10'h258 |=>
        cycle_period_setting == tpo_pkg::CYCLE_MAX_SEC)
        else $error("cycle period not held at its ceiling");
    chk_ripple_flag: assert property (
        ripple_mode == (timed && cycle_period_setting == 10'h000))
        else $error("ripple mode flag wrong");
    chk_drive_sense: assert property (
        $past(rst_n) && $stable(output_on) && $stable(invert_sense)
        |-> drive_out == (output_on ^ invert_sense))
        else $error("output pin sense wrong");
    chk_input_sense: assert property (
        $past(rst_n) |-> input_active == $past(digital_in ^ invert_sense))
        else $error("digital input sense wrong");
    chk_onoff_follow: assert property (!timed |=> output_on == $past(switch_request))
        else $error("on/off output does not follow its request");
    chk_full_on: assert property (timed && $past(timed) && demand >= 10'h3e8 &&
        $past(demand) >= 10'h3e8 && $past(output_on) |-> output_on)
        else $error("full demand output switched off");
endmodule

bind time_proportioning_output tpo_properties #(.TICK_CYCLES(TICK_CYCLES)) props (
    .clk(clk), .rst_n(rst_n), .demand(demand), .output_mode(output_mode),
    .hw_is_relay(hw_is_relay), .invert_sense(invert_sense), .switch_request(switch_request),
    .digital_in(digital_in), .cfg_load(cfg_load), .cfg_defaults(cfg_defaults),
    .cfg_min_pulse(cfg_min_pulse), .cfg_cycle_period(cfg_cycle_period),
    .min_pulse_setting(min_pulse_setting), .cycle_period_setting(cycle_period_setting),
    .drive_out(drive_out), .output_on(output_on), .input_active(input_active),
    .ripple_mode(ripple_mode));

// ### dv/time_proportioning_output_tb.sv
// Self-checking bench for the time-proportioning output channel
`timescale 1ns/1ps

module time_proportioning_output_tb;
    localparam int unsigned TC  = 4;
    localparam int unsigned TPS = tpo_pkg::TICKS_PER_SEC;
    logic                     clk, rst_n, hw_is_relay, invert_sense, switch_request;
    logic                     digital_in, cfg_load, cfg_defaults, drive_out, output_on;
    logic                     input_active, ripple_mode;
    logic [9:0]               demand, cfg_cycle_period, cycle_period_setting;
    logic [15:0]              cfg_min_pulse, min_pulse_setting;
    logic [31:0]              on_len, off_len, n_edges, base;
    tpo_pkg::output_mode_type output_mode;
    int                       miscompares = 0;
    int                       n_checks = 0;

    time_proportioning_output #(.TICK_CYCLES(TC)) DUT (.clk(clk), .rst_n(rst_n),
        .demand(demand), .output_mode(output_mode), .hw_is_relay(hw_is_relay),
        .invert_sense(invert_sense), .switch_request(switch_request),
        .digital_in(digital_in), .cfg_load(cfg_load), .cfg_defaults(cfg_defaults),
        .cfg_min_pulse(cfg_min_pulse), .cfg_cycle_period(cfg_cycle_period),
        .min_pulse_setting(min_pulse_setting), .cycle_period_setting(cycle_period_setting),
        .drive_out(drive_out), .output_on(output_on), .input_active(input_active),
        .ripple_mode(ripple_mode));
    actuator_load load (.clk(clk), .rst_n(rst_n), .drive_out(drive_out), .on_len(on_len),
        .off_len(off_len), .n_edges(n_edges));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input int tol,
                         input string what);
        n_checks++;
        if ((seen + 32'(tol) >= exp && seen <= exp + 32'(tol)) !== 1'b1) begin
            miscompares++;
            $display("mismatch at %0t: %s saw %0d expected %0d", $time, what, seen, exp);
        end
    endtask

    task automatic cfg(input logic [15:0] mp, input logic [9:0] cp, input logic clear);
        {cfg_min_pulse, cfg_cycle_period, cfg_load, cfg_defaults} = {mp, cp, 1'b1, clear};
        cyc(1);
        {cfg_load, cfg_defaults} = 2'h0;
        cyc(1);
    endtask

    // Skips the phase in flight at a settings change; on-phase end may slip by one tick
    task automatic phases(input logic [31:0] on_exp, input logic [31:0] off_exp);
        base = n_edges;
        for (int k = 0; k < 20000 && n_edges < base + 32'h6; k++) begin
            cyc(1);
        end
        check(n_edges - base, 32'h6, 0, "phase count");
        check(on_len, on_exp, TC, "on phase");
        check(off_len, off_exp, TC, "off phase");
    endtask

    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        #3_000_000;
        miscompares++;
        end_sim();
    end

    initial begin
        {hw_is_relay, invert_sense, switch_request, digital_in, cfg_load, cfg_defaults} = 6'h00;
        {demand, cfg_cycle_period, cfg_min_pulse, rst_n} = 37'h0;
        output_mode = tpo_pkg::MODE_ON_OFF;
        cyc(10);
        rst_n = 1'b1;
        cyc(2);
        check(32'(min_pulse_setting) + 32'(cycle_period_setting), 32'h0, 0, "reset");
        cfg(16'h0014, 10'h2bc, 1'b0);
        check(32'(min_pulse_setting), 32'h14, 0, "min pulse load");
        check(32'(cycle_period_setting), 32'h258, 0, "cycle above ceiling");
        cfg(16'h0014, 10'h001, 1'b1);
        check(32'(min_pulse_setting) + 32'(cycle_period_setting), 32'h0, 0, "clear");
        $display("test config done");
        for (int i = 0; i < 4; i++) begin
            {invert_sense, digital_in, switch_request} = {i[1], i[0], i[0]};
            cyc(2);
            check(32'(input_active), 32'(i[0] ^ i[1]), 0, "input sense");
            check(32'(output_on), 32'(i[0]), 0, "on/off follow");
            check(32'(drive_out), 32'(i[0] ^ i[1]), 0, "output sense");
        end
        {invert_sense, switch_request, demand} = {2'h0, 10'h1f4};
        cyc(500);
        $display("test sense done");
        for (int m = 2; m < 4; m++) begin
            output_mode = tpo_pkg::output_mode_type'(m);
            cyc(1);
            check(32'(ripple_mode), 32'h1, 0, "ripple flag");
            phases(2 * TC * tpo_pkg::VALVE_MIN, 2 * TC * tpo_pkg::VALVE_MIN);
        end
        $display("test ripple done");
        output_mode = tpo_pkg::MODE_TIME_PROP;
        demand      = 10'h0fa;
        cfg(16'h0000, 10'h001, 1'b0);
        check(32'(ripple_mode), 32'h0, 0, "constant cycle flag");
        phases(TC * TPS / 4, TC * TPS * 3 / 4);
        hw_is_relay = 1'b1;
        // Quarter duty with a one-second relay pulse stretches the period to four pulses
        cfg(16'h000a, 10'h001, 1'b0);
        phases(TC * tpo_pkg::RELAY_TPO_MIN, 3 * TC * tpo_pkg::RELAY_TPO_MIN);
        $display("test cycle done");
        demand = 10'h3e8;
        cyc(2000);
        base = n_edges;
        cyc(1000);
        check(n_edges, base, 0, "full demand switching");
        check(32'(output_on), 32'h1, 0, "full demand on");
        $display("test full demand done");
        demand = 10'h000;
        cyc(1000);
        base = n_edges;
        cyc(1000);
        check(n_edges, base, 0, "zero demand switching");
        check(32'(drive_out), 32'h0, 0, "zero demand off");
        $display("test zero demand done");
        end_sim();
    end
endmodule
